// ### hw/rts_pkg.sv
// Package: constants and types for the reset timeout sequencer
`default_nettype none
package rts_pkg;
  // AXI4-Lite register map
  localparam logic [3:0] RTS_ADDR_FLAGS  = 4'h0;
  localparam logic [3:0] RTS_ADDR_CONFIG = 4'h4;
  localparam logic [3:0] RTS_ADDR_STATUS = 4'h8;
  localparam logic [3:0] RTS_ADDR_RETAIN = 4'hc;
  localparam logic [1:0] RTS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RTS_RESP_SLVERR = 2'h2;
  // Config field positions
  localparam int RTS_CFG_OSC_LO   = 0;
  localparam int RTS_CFG_PUT_DISN = 3;
  localparam int RTS_CFG_SD_EN    = 6;
  localparam int RTS_CFG_SD_LVL   = 7;
  localparam logic [7:0] RTS_CFG_RESET = 8'hc8;
  // Oscillator mode encodings
  localparam logic [1:0] RTS_OSC_LP = 2'h0;
  localparam logic [1:0] RTS_OSC_XT = 2'h1;
  localparam logic [1:0] RTS_OSC_HS = 2'h2;
  localparam logic [1:0] RTS_OSC_RC = 2'h3;
  // Timing
  localparam int RTS_CLK_HZ        = 10_000_000;
  localparam int RTS_RC_DIV        = 10;
  localparam int RTS_PUT_MS        = 72;
  localparam int RTS_PUT_TICKS_DEF =
    RTS_PUT_MS * (RTS_CLK_HZ / RTS_RC_DIV / 1000);
  localparam int RTS_OST_CYCLES    = 1024;
  localparam int RTS_PIN_FILT      = 4;
  localparam int RTS_SD_MIN_DEF    = 1000;
  localparam int RTS_POR_DELAY     = 16;
  typedef enum logic [2:0] {
    RTS_CAUSE_NONE, RTS_CAUSE_POR, RTS_CAUSE_PIN_RUN, RTS_CAUSE_PIN_SLEEP,
    RTS_CAUSE_WDT_RESET, RTS_CAUSE_WDT_WAKE, RTS_CAUSE_SUPPLY_DROP,
    RTS_CAUSE_INT_WAKE
  } rts_cause_t;
  typedef enum logic [2:0] {
    RTS_ST_POR_DLY, RTS_ST_WAIT_SUPPLY, RTS_ST_PUT, RTS_ST_OST, RTS_ST_RUN
  } rts_state_t;
  typedef struct packed {
    logic low_supply;
    logic below_4v0;
    logic below_2v5;
  } rts_supply_t;
  typedef struct packed {
    logic wdt_timeout;
    logic wake_wdt;
    logic wake_int;
    logic asleep;
  } rts_core_ev_t;
endpackage
`default_nettype wire

// ### hw/rts_pin_filter.sv
// Module: glitch filter for the external reset pin
`default_nettype none
module rts_pin_filter
  import rts_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin level in, filtered level out
  input  wire logic pin_n,
  output var  logic level_n
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       lvl;
  } rts_filt_t;
  rts_filt_t st;
  rts_filt_t next_st;
  localparam logic [3:0] FILT_MAX = 4'(RTS_PIN_FILT);

  always_comb
  begin
    next_st = st;
    // Level must stay changed for several cycles to be taken
    if (pin_n == st.lvl)
    begin
      next_st.cnt = 4'h0;
    end
    else if (st.cnt == FILT_MAX - 4'h1)
    begin
      next_st.lvl = pin_n;
      next_st.cnt = 4'h0;
    end
    else
    begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '{cnt: 4'h0, lvl: 1'b1};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level_n = st.lvl;
endmodule
`default_nettype wire

// ### hw/rts_sequencer.sv
// Module: reset timeout sequencer with AXI4-Lite flag and config access
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int PUT_TICKS = RTS_PUT_TICKS_DEF,
  parameter int SD_MIN    = RTS_SD_MIN_DEF
)
(
  // Clock and power-on pulse
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Supply monitors and pins
  input  wire rts_supply_t  supply,
  input  wire logic         external_reset_pin_n,
  input  wire logic         osc_input_pin,
  // Core events
  input  wire rts_core_ev_t core_ev,
  // Reset outputs
  output logic              core_reset,
  output logic              regs_reset,
  output rts_cause_t        last_cause,
  // AXI4-Lite slave
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready
);
  localparam logic [23:0] PUT_END  = 24'(PUT_TICKS);
  localparam logic [15:0] SD_END   = 16'(SD_MIN);
  localparam logic [10:0] OST_END  = 11'(RTS_OST_CYCLES);
  localparam logic [4:0]  POR_END  = 5'(RTS_POR_DELAY);
  localparam logic [3:0]  DIV_END  = 4'(RTS_RC_DIV - 1);

  typedef struct packed {
    rts_state_t  state;
    logic [4:0]  por_cnt;
    logic [3:0]  rc_div;
    logic [23:0] put_cnt;
    logic [10:0] ost_cnt;
    logic        osc_q;
    logic [15:0] sd_cnt;
    logic        pin_prev;
    logic        was_por;
    logic [7:0]  cfg;
    logic [1:0]  flags;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic [31:0] retain;
    rts_cause_t  cause;
    logic        core_reset;
    logic        regs_reset;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rts_regs_t;

  rts_regs_t st;
  rts_regs_t next_st;
  logic      pin_level_n;

  rts_pin_filter u_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_n   (external_reset_pin_n),
    .level_n (pin_level_n)
  );

  logic sd_en;
  logic below;
  logic crystal;
  logic put_en;
  logic rc_tick;
  logic osc_rise;
  logic sd_trip;
  logic pin_fall;
  logic wr_go;
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb
  begin
    next_st  = st;
    sd_en    = st.cfg[RTS_CFG_SD_EN];
    below    = st.cfg[RTS_CFG_SD_LVL] ? supply.below_4v0
                                      : supply.below_2v5;
    crystal  = st.cfg[RTS_CFG_OSC_LO +: 2] != RTS_OSC_RC;
    put_en   = !st.cfg[RTS_CFG_PUT_DISN];
    rc_tick  = st.rc_div == DIV_END;
    osc_rise = osc_input_pin && !st.osc_q;
    sd_trip  = 1'b0;
    pin_fall = !pin_level_n && st.pin_prev;
    wr_go    = 1'b0;
    rd_val   = 32'h0;
    rd_ok    = 1'b1;
    next_st.osc_q    = osc_input_pin;
    next_st.pin_prev = pin_level_n;
    next_st.regs_reset = 1'b0;
    // Internal RC clock as one-cycle enable
    next_st.rc_div = rc_tick ? 4'h0 : st.rc_div + 4'h1;

    // Supply-drop qualification
    if (sd_en && below && st.state != RTS_ST_POR_DLY)
    begin
      if (st.sd_cnt == SD_END)
      begin
        sd_trip = 1'b1;
      end
      else
      begin
        next_st.sd_cnt = st.sd_cnt + 16'h1;
      end
    end
    else
    begin
      next_st.sd_cnt = 16'h0;
    end

    case (st.state)
      RTS_ST_POR_DLY:
      begin
        next_st.core_reset = 1'b1;
        if (st.por_cnt == POR_END)
        begin
          next_st.state = RTS_ST_WAIT_SUPPLY;
        end
        else
        begin
          next_st.por_cnt = st.por_cnt + 5'h1;
        end
      end
      RTS_ST_WAIT_SUPPLY:
      begin
        next_st.core_reset = 1'b1;
        next_st.put_cnt    = 24'h0;
        next_st.ost_cnt    = 11'h0;
        if (!(sd_en && below) && !supply.low_supply)
        begin
          if (put_en && (st.was_por || st.cause == RTS_CAUSE_SUPPLY_DROP))
          begin
            next_st.state = RTS_ST_PUT;
          end
          else if (crystal && st.was_por)
          begin
            next_st.state = RTS_ST_OST;
          end
          else
          begin
            next_st.state = RTS_ST_RUN;
          end
        end
      end
      RTS_ST_PUT:
      begin
        next_st.core_reset = 1'b1;
        if (sd_trip)
        begin
          next_st.state = RTS_ST_WAIT_SUPPLY;
        end
        else if (st.put_cnt == PUT_END)
        begin
          next_st.state = crystal ? RTS_ST_OST : RTS_ST_RUN;
        end
        else if (rc_tick)
        begin
          next_st.put_cnt = st.put_cnt + 24'h1;
        end
      end
      RTS_ST_OST:
      begin
        next_st.core_reset = 1'b1;
        if (st.ost_cnt == OST_END)
        begin
          next_st.state   = RTS_ST_RUN;
          next_st.was_por = 1'b0;
        end
        else if (osc_rise)
        begin
          next_st.ost_cnt = st.ost_cnt + 11'h1;
        end
      end
      RTS_ST_RUN:
      begin
        // Filtered pin holds reset but not the time-outs
        next_st.core_reset = !pin_level_n;
        next_st.was_por    = 1'b0;
      end
      default:
      begin
        next_st.state = RTS_ST_WAIT_SUPPLY;
      end
    endcase

    // Cause detection, highest priority last
    if (st.state == RTS_ST_RUN || st.state == RTS_ST_OST)
    begin
      if (core_ev.wake_int && core_ev.asleep)
      begin
        next_st.cause          = RTS_CAUSE_INT_WAKE;
        next_st.timeout_flag   = 1'b1;
        next_st.powerdown_flag = 1'b0;
      end
      if (core_ev.wake_wdt && core_ev.asleep)
      begin
        // Resumes: no register reset, crystal restarts
        next_st.cause          = RTS_CAUSE_WDT_WAKE;
        next_st.timeout_flag   = 1'b0;
        next_st.powerdown_flag = 1'b0;
        if (crystal)
        begin
          next_st.state   = RTS_ST_OST;
          next_st.ost_cnt = 11'h0;
        end
      end
      if (core_ev.wdt_timeout && !core_ev.asleep)
      begin
        // Internal only; nothing drives the pin
        next_st.cause          = RTS_CAUSE_WDT_RESET;
        next_st.timeout_flag   = 1'b0;
        next_st.powerdown_flag = 1'b1;
        next_st.regs_reset     = 1'b1;
        next_st.core_reset     = 1'b1;
      end
      if (pin_fall)
      begin
        next_st.regs_reset = 1'b1;
        if (core_ev.asleep)
        begin
          next_st.cause          = RTS_CAUSE_PIN_SLEEP;
          next_st.timeout_flag   = 1'b1;
          next_st.powerdown_flag = 1'b0;
        end
        else
        begin
          next_st.cause = RTS_CAUSE_PIN_RUN;
        end
      end
    end
    if (sd_trip)
    begin
      next_st.cause          = RTS_CAUSE_SUPPLY_DROP;
      next_st.state          = RTS_ST_WAIT_SUPPLY;
      next_st.core_reset     = 1'b1;
      next_st.regs_reset     = 1'b1;
      next_st.timeout_flag   = 1'b1;
      next_st.powerdown_flag = 1'b1;
    end

    // AXI4-Lite write
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_got  = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      wr_go          = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RTS_RESP_OKAY;
      case (st.awaddr)
        RTS_ADDR_FLAGS:
        begin
          if (st.wstrb[0])
          begin
            next_st.flags = st.wdata[1:0];
          end
        end
        RTS_ADDR_CONFIG:
        begin
          if (st.wstrb[0])
          begin
            next_st.cfg = st.wdata[7:0];
          end
        end
        RTS_ADDR_RETAIN:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (st.wstrb[b])
            begin
              next_st.retain[8*b +: 8] = st.wdata[8*b +: 8];
            end
          end
        end
        RTS_ADDR_STATUS:
        begin
          next_st.bresp = RTS_RESP_OKAY;
        end
        default:
        begin
          next_st.bresp = RTS_RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end
    // Hardware flag events win over a software write
    if (sd_trip)
    begin
      next_st.flags[0] = 1'b0;
    end

    // AXI4-Lite read
    case (s_axi_araddr)
      RTS_ADDR_FLAGS:  rd_val = {30'h0, st.flags};
      RTS_ADDR_CONFIG: rd_val = {24'h0, st.cfg};
      RTS_ADDR_STATUS: rd_val = {24'h0, st.timeout_flag,
                                 st.powerdown_flag, st.core_reset,
                                 st.cause, st.state[1:0]};
      RTS_ADDR_RETAIN: rd_val = st.retain;
      default:         rd_ok  = 1'b0;
    endcase
    if (s_axi_arvalid && st.arready)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = rd_val;
      next_st.rresp   = rd_ok ? RTS_RESP_OKAY : RTS_RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
    if (wr_go)
    begin
      next_st.awready = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Power-on reset: retain is left alone, flag bit 0 set and bit 1 cleared
      st.state          <= RTS_ST_POR_DLY;
      st.por_cnt        <= 5'h0;
      st.rc_div         <= 4'h0;
      st.put_cnt        <= 24'h0;
      st.ost_cnt        <= 11'h0;
      st.osc_q          <= 1'b0;
      st.sd_cnt         <= 16'h0;
      st.pin_prev       <= 1'b1;
      st.was_por        <= 1'b1;
      st.cfg            <= RTS_CFG_RESET;
      st.flags[1]       <= 1'b0;
      st.flags[0]       <= 1'b1;
      st.timeout_flag   <= 1'b1;
      st.powerdown_flag <= 1'b1;
      st.cause          <= RTS_CAUSE_POR;
      st.core_reset     <= 1'b1;
      st.regs_reset     <= 1'b1;
      st.aw_got         <= 1'b0;
      st.w_got          <= 1'b0;
      st.awaddr         <= 4'h0;
      st.wdata          <= 32'h0;
      st.wstrb          <= 4'h0;
      st.awready        <= 1'b1;
      st.wready         <= 1'b1;
      st.bvalid         <= 1'b0;
      st.bresp          <= RTS_RESP_OKAY;
      st.arready        <= 1'b1;
      st.rvalid         <= 1'b0;
      st.rdata          <= 32'h0;
      st.rresp          <= RTS_RESP_OKAY;
      st.retain         <= next_st.retain;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign core_reset    = st.core_reset;
  assign regs_reset    = st.regs_reset;
  assign last_cause    = st.cause;
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
endmodule
`default_nettype wire

// ### tb/rts_monitor.sv
// Checker: bus handshake and reset sequence assertions
`default_nettype none
module rts_monitor
  import rts_pkg::*;
(
  // Clock and power-on pulse
  input wire logic        aclk,
  input wire logic        aresetn,
  // Pin and reset outputs
  input wire logic        external_reset_pin_n,
  input wire logic        core_reset,
  input wire logic        regs_reset,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Two-cycle low pulse on the pin while running
  sequence glitch_s;
    !core_reset && $fell(external_reset_pin_n) ##1 !external_reset_pin_n
      ##1 external_reset_pin_n;
  endsequence
  por_hold_a:
    assert property ($rose(aresetn) |-> core_reset[*8])
    else $error("core left reset too early after power-on");
  pin_reset_a:
    assert property (!external_reset_pin_n[*6] |-> ##[0:3] core_reset)
    else $error("held pin did not reset the core");
  glitch_ignore_a:
    assert property (glitch_s |-> !core_reset[*6])
    else $error("short pin pulse reset the core");
  run_pin_high_a:
    assert property ($fell(core_reset) |-> external_reset_pin_n)
    else $error("core released while pin low");
  clear_pair_a:
    assert property (regs_reset |-> ##[0:2] core_reset)
    else $error("register clear without core reset");
  rd_latency_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_latency_a:
    assert property (wr_taken_s |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  wr_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  bus_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
endmodule
bind rts_sequencer rts_monitor u_monitor (
  .aclk, .aresetn, .external_reset_pin_n, .core_reset, .regs_reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ### tb/rts_partner.sv
// Partner: supply monitors and free-running crystal source
`default_nettype none
module rts_partner
  import rts_pkg::*;
#(
  parameter logic [15:0] LOW_MV = 16'h708
)
(
  // Supply level in millivolts
  input  wire logic [15:0] supply_mv,
  // Monitor levels and oscillator
  output var rts_supply_t  supply,
  output var logic         osc_input_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  assign supply.below_4v0 = supply_mv < 16'hfa0;
  assign supply.below_2v5 = supply_mv < 16'h9c4;
  assign supply.low_supply = supply_mv < LOW_MV;
  // Offset keeps crystal edges clear of the bench clock edges
  initial
  begin
    osc_input_pin = 1'b0;
    #0.3;
    forever #137 osc_input_pin = ~osc_input_pin;
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Testbench: self-checking run of the reset timeout sequencer
`default_nettype none
module testbench
  import rts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         aclk, aresetn, external_reset_pin_n, osc_input_pin;
  logic         core_reset, regs_reset;
  logic [15:0]  supply_mv;
  rts_supply_t  supply;
  rts_core_ev_t core_ev;
  rts_cause_t   last_cause;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]  s_axi_wdata, s_axi_rdata, retain_val;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [65:0]  exp_q[$];
  logic [65:0]  e;
  int           bad_count, check_count, seed, n, rr_cnt, rr0;
  logic [3:0]   ev_tab[3] = '{4'h8, 4'h5, 4'h3};
  logic [31:0]  st_tab[3] = '{32'h50, 32'h14, 32'h9c};
  int           rr_tab[3] = '{1, 0, 0};
  rts_partner u_partner (.supply_mv, .supply, .osc_input_pin);
  rts_sequencer #(.PUT_TICKS(20), .SD_MIN(5)) uut (
    .aclk, .aresetn, .supply, .external_reset_pin_n, .osc_input_pin,
    .core_ev, .core_reset, .regs_reset, .last_cause, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_ok(input string what, input logic ok);
    check(what, 32'h1, {31'h0, ok});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bus results compared against the oldest expectation
  always @(posedge aclk)
  begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
    begin
      e = exp_q.pop_front();
      if (s_axi_rvalid)
        check("rdata", e[31:0], s_axi_rdata & e[63:32]);
      check("resp", {30'h0, e[65:64]},
            {30'h0, s_axi_rvalid ? s_axi_rresp : s_axi_bresp});
    end
  end
  always @(posedge aclk)
    if (regs_reset === 1'b1)
      rr_cnt++;
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, 64'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready)
           || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid)
      @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, m, d & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic run_wait();
    n = 0;
    while (core_reset !== 1'b0)
    begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic quiet();
    repeat (10)
    begin
      @(posedge aclk);
      check_ok("core idle", core_reset === 1'b0);
    end
  endtask
  task automatic pin_low(input int k);
    external_reset_pin_n <= 1'b0;
    repeat (k) @(posedge aclk);
    external_reset_pin_n <= 1'b1;
  endtask
  task automatic dip(input logic [15:0] mv, input int k);
    supply_mv <= mv;
    repeat (k) @(posedge aclk);
    supply_mv <= 16'h1388;
  endtask
  initial
  begin
    #2_000_000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    seed = 13;
    aresetn = 1'b0;
    external_reset_pin_n = 1'b1;
    supply_mv = 16'h1388;
    core_ev = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    run_wait();
    check_ok("power-on hold", n > 2800 && n < 2900);
    rd(RTS_ADDR_CONFIG, 32'hc8, 32'hff, RTS_RESP_OKAY);
    rd(RTS_ADDR_FLAGS, 32'h1, 32'h3, RTS_RESP_OKAY);
    rd(RTS_ADDR_STATUS, 32'hc4, 32'hfc, RTS_RESP_OKAY);
    retain_val = $random(seed);
    wr(RTS_ADDR_RETAIN, retain_val, RTS_RESP_OKAY);
    wr(RTS_ADDR_FLAGS, 32'h3, RTS_RESP_OKAY);
    wr(RTS_ADDR_STATUS, 32'h0, RTS_RESP_OKAY);
    rd(4'h2, 32'h0, 32'h0, RTS_RESP_SLVERR);
    wr(4'h2, 32'h0, RTS_RESP_SLVERR);
    pin_low(2);
    quiet();
    pin_low(20);
    run_wait();
    check_ok("pin release", n < 8);
    rd(RTS_ADDR_FLAGS, 32'h3, 32'h3, RTS_RESP_OKAY);
    rd(RTS_ADDR_RETAIN, retain_val, 32'hffffffff, RTS_RESP_OKAY);
    rd(RTS_ADDR_STATUS, 32'hc8, 32'hfc, RTS_RESP_OKAY);
    wr(RTS_ADDR_CONFIG, 32'hc3, RTS_RESP_OKAY);
    dip(16'hbb8, 2);
    quiet();
    dip(16'hbb8, 80);
    check_ok("drop hold", core_reset === 1'b1);
    repeat (100) @(posedge aclk);
    dip(16'hbb8, 20);
    run_wait();
    check_ok("timer restart", n > 185 && n < 230);
    rd(RTS_ADDR_FLAGS, 32'h2, 32'h3, RTS_RESP_OKAY);
    rd(RTS_ADDR_STATUS, 32'hd8, 32'hfc, RTS_RESP_OKAY);
    wr(RTS_ADDR_CONFIG, 32'hcb, RTS_RESP_OKAY);
    dip(16'hbb8, 20);
    run_wait();
    check_ok("no time-out", n < 8);
    wr(RTS_ADDR_CONFIG, 32'h4b, RTS_RESP_OKAY);
    supply_mv <= 16'hbb8;
    quiet();
    dip(16'h7d0, 20);
    check_ok("low level drop", core_reset === 1'b1);
    run_wait();
    wr(RTS_ADDR_CONFIG, 32'h8b, RTS_RESP_OKAY);
    supply_mv <= 16'h7d0;
    quiet();
    supply_mv <= 16'h1388;
    for (int i = 0; i < 3; i++)
    begin
      rr0 = rr_cnt;
      core_ev <= {3'h0, ev_tab[i][0]};
      @(posedge aclk);
      core_ev <= ev_tab[i];
      @(posedge aclk);
      core_ev <= '0;
      repeat (4) @(posedge aclk);
      run_wait();
      rd(RTS_ADDR_STATUS, st_tab[i], 32'hfc, RTS_RESP_OKAY);
      check("clear pulses", rr_tab[i], rr_cnt - rr0);
      check("cause", {29'h0, st_tab[i][4:2]}, {29'h0, last_cause});
    end
    core_ev <= 4'h1;
    pin_low(20);
    run_wait();
    core_ev <= '0;
    rd(RTS_ADDR_STATUS, 32'h8c, 32'hfc, RTS_RESP_OKAY);
    finish_test();
  end
endmodule
`default_nettype wire
